// ==== isr_pkg.sv ====
package isr_pkg;
  localparam logic [6:0] ADDR_ID      = 7'h00;
  localparam logic [6:0] ADDR_RPMAX   = 7'h01;
  localparam logic [6:0] ADDR_RPMIN   = 7'h02;
  localparam logic [6:0] ADDR_WDOG    = 7'h03;
  localparam logic [6:0] ADDR_CONF    = 7'h04;
  localparam logic [6:0] ADDR_RSV1    = 7'h05;
  localparam logic [6:0] ADDR_RSVFF   = 7'h06;
  localparam logic [6:0] ADDR_THI     = 7'h07;
  localparam logic [6:0] ADDR_RSV0    = 7'h08;
  localparam logic [6:0] ADDR_TLO     = 7'h09;
  localparam logic [6:0] ADDR_IRQCFG  = 7'h0a;
  localparam logic [6:0] ADDR_PWR     = 7'h0b;
  localparam logic [6:0] ADDR_STATUS  = 7'h20;
  localparam logic [6:0] ADDR_RSVRO   = 7'h21;
  localparam logic [6:0] ADDR_PROX    = 7'h22;
  localparam logic [6:0] ADDR_FC_LO   = 7'h23;
  localparam logic [6:0] ADDR_FC_MID  = 7'h24;
  localparam logic [6:0] ADDR_FC_HI   = 7'h25;
  localparam logic [6:0] LOCK_LO      = 7'h01;
  localparam logic [6:0] LOCK_HI      = 7'h05;
  localparam logic [7:0] RST_RPMAX    = 8'h0e;
  localparam logic [7:0] RST_RPMIN    = 8'h14;
  localparam logic [7:0] RST_WDOG     = 8'h45;
  localparam logic [7:0] RST_CONF     = 8'h1b;
  localparam logic [7:0] RST_RSV1     = 8'h01;
  localparam logic [7:0] RST_RSVFF    = 8'hff;
  localparam logic [7:0] RST_THI      = 8'hff;
  localparam logic [7:0] RST_RSV0     = 8'h00;
  localparam logic [7:0] RST_TLO      = 8'h00;
  localparam logic [7:0] RST_IRQCFG   = 8'h00;
  localparam logic [7:0] RST_PWR      = 8'h00;
  localparam logic [4:0] RPMAX_TOP    = 5'h1f;
  localparam int         PWR_BIT      = 0;
  localparam int         ST_OSC       = 7;
  localparam int         ST_RDY_N     = 6;
  localparam int         ST_WAKE      = 5;
  localparam int         ST_CMP       = 4;
  localparam int         CMD_RD_BIT   = 7;
  localparam logic [2:0] CMD_LAST_BIT = 3'h7;
endpackage

// ==== isr_regbank.sv ====
`timescale 1ns/1ps
// How it works
// - registers one to five locked while active
// - upper limit takes any code 0x00..0xFF, reset 0x0E
// - status at 0x20 read-only, four flags high
// - id, 0x05, status, 0x21, result, count read-only; rest writable
// - command byte: read bit then address
// - address auto-increments per further byte
// - count bytes show the live count input, read as each byte starts
// - start in standby until power bit set
module isr_regbank #(
  parameter logic [7:0] ID_VALUE = 8'h5a  // arbitrary identification value
) (
  input  wire logic        clk,           // system clock, 250 MHz
  input  wire logic        rst_n,         // synchronous reset, active low
  input  wire logic        spi_cs_n,      // chip select pin, active low
  input  wire logic        spi_sclk,      // serial clock pin
  input  wire logic        spi_mosi,      // serial data in
  output logic             spi_miso,      // serial data out
  output logic             spi_miso_oe,   // high while driving serial data out
  input  wire logic        osc_flag,      // oscillator flag from core
  input  wire logic        conv_ready_n,  // conversion ready flag, active low
  input  wire logic        wake_flag,     // wake-up flag from core
  input  wire logic        cmp_flag,      // comparator flag from core
  input  wire logic [7:0]  prox_data,     // proximity result from core
  input  wire logic [23:0] freq_count,    // frequency count from core
  output logic [7:0]       upper_resistance_limit,        // upper resistance limit code
  output logic [7:0]       lower_resistance_limit,        // lower resistance limit code
  output logic [7:0]       wdog_freq,     // watchdog frequency setting
  output logic [7:0]       conv_cfg,      // converter configuration
  output logic [7:0]       thr_high,      // upper threshold
  output logic [7:0]       thr_low,       // lower threshold
  output logic [2:0]       irq_pin_mode,  // irq pin mode field
  output logic             active         // power state bit: converting
);

  // pin stages: two flops settle each pin; sclk's third feeds edge detection, cs's third is unused
  typedef struct packed {
    logic [2:0]  cs_s;
    logic [2:0]  sck_s;
    logic [1:0]  mosi_s;
    logic [2:0]  bitc;
    logic        cmd_done;
    logic        rd;
    logic [6:0]  addr;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        miso;
    logic        miso_oe;
    logic [7:0]  rpmax;
    logic [7:0]  rpmin;
    logic [7:0]  wdog;
    logic [7:0]  conf;
    logic [7:0]  rsvff;
    logic [7:0]  thi;
    logic [7:0]  rsv0;
    logic [7:0]  tlo;
    logic [7:0]  irqcfg;
    logic [7:0]  pwr;
  } isr_state_type;

  isr_state_type st_r, st_nxt;

  function automatic logic [7:0] read_reg(input isr_state_type s, input logic [6:0] a,
                                          input logic [7:0] stat, input logic [7:0] prox,
                                          input logic [23:0] fc);
    case (a)
      isr_pkg::ADDR_ID:     read_reg = ID_VALUE;
      isr_pkg::ADDR_RPMAX:  read_reg = s.rpmax;
      isr_pkg::ADDR_RPMIN:  read_reg = s.rpmin;
      isr_pkg::ADDR_WDOG:   read_reg = s.wdog;
      isr_pkg::ADDR_CONF:   read_reg = s.conf;
      isr_pkg::ADDR_RSV1:   read_reg = isr_pkg::RST_RSV1;
      isr_pkg::ADDR_RSVFF:  read_reg = s.rsvff;
      isr_pkg::ADDR_THI:    read_reg = s.thi;
      isr_pkg::ADDR_RSV0:   read_reg = s.rsv0;
      isr_pkg::ADDR_TLO:    read_reg = s.tlo;
      isr_pkg::ADDR_IRQCFG: read_reg = s.irqcfg;
      isr_pkg::ADDR_PWR:    read_reg = s.pwr;
      isr_pkg::ADDR_STATUS: read_reg = stat;
      isr_pkg::ADDR_PROX:   read_reg = prox;
      isr_pkg::ADDR_FC_LO:  read_reg = fc[7:0];
      isr_pkg::ADDR_FC_MID: read_reg = fc[15:8];
      isr_pkg::ADDR_FC_HI:  read_reg = fc[23:16];
      default:              read_reg = 8'h00;
    endcase
  endfunction

  logic       cs_act, sck_rise, sck_fall, locked;
  logic [7:0] status, rbyte, wbyte;

  // sclk is oversampled by clk; a 250 MHz clock leaves ample margin for
  // the slowest host, but sclk above roughly clk/8 would present miso data too late for the rising edge
  always_comb begin
    cs_act   = ~st_r.cs_s[1];
    sck_rise = st_r.sck_s[1] & ~st_r.sck_s[2];
    sck_fall = ~st_r.sck_s[1] & st_r.sck_s[2];
    // low nibble reads zero; flags are sampled straight from the core
    status   = {osc_flag, conv_ready_n, wake_flag, cmp_flag, 4'h0};
    locked   = st_r.pwr[isr_pkg::PWR_BIT];
    rbyte    = read_reg(st_r, st_r.addr, status, prox_data, freq_count);
    wbyte    = {st_r.sh[6:0], st_r.mosi_s[1]};
    st_nxt   = st_r;
    st_nxt.cs_s   = {st_r.cs_s[1:0], spi_cs_n};
    st_nxt.sck_s  = {st_r.sck_s[1:0], spi_sclk};
    st_nxt.mosi_s = {st_r.mosi_s[0], spi_mosi};
    if (!cs_act) begin
      st_nxt.bitc     = 3'h0;
      st_nxt.cmd_done = 1'b0;
      st_nxt.miso_oe  = 1'b0;
      st_nxt.miso     = 1'b0;
    end else begin
      if (sck_rise) begin
        st_nxt.sh   = wbyte;
        st_nxt.bitc = st_r.bitc + 3'h1;
        if (st_r.bitc == isr_pkg::CMD_LAST_BIT) begin
          if (!st_r.cmd_done) begin
            st_nxt.cmd_done = 1'b1;
            st_nxt.rd       = wbyte[isr_pkg::CMD_RD_BIT];
            st_nxt.addr     = wbyte[6:0];
            st_nxt.tx       = read_reg(st_r, wbyte[6:0], status, prox_data, freq_count);
          end else begin
            st_nxt.addr = st_r.addr + 7'h01;
            st_nxt.tx   = read_reg(st_r, st_r.addr + 7'h01, status, prox_data, freq_count);
            if (!st_r.rd) begin
              // partial bytes never write: only a complete eighth edge lands here
              if (!(locked && st_r.addr >= isr_pkg::LOCK_LO
                    && st_r.addr <= isr_pkg::LOCK_HI)) begin
                unique case (st_r.addr)
                  isr_pkg::ADDR_RPMAX:  st_nxt.rpmax = wbyte;
                  isr_pkg::ADDR_RPMIN:  st_nxt.rpmin = wbyte;
                  isr_pkg::ADDR_WDOG:   st_nxt.wdog  = wbyte;
                  isr_pkg::ADDR_CONF:   st_nxt.conf  = wbyte;
                  isr_pkg::ADDR_RSVFF:  st_nxt.rsvff = wbyte;
                  isr_pkg::ADDR_THI:    st_nxt.thi   = wbyte;
                  isr_pkg::ADDR_RSV0:   st_nxt.rsv0  = wbyte;
                  isr_pkg::ADDR_TLO:    st_nxt.tlo   = wbyte;
                  isr_pkg::ADDR_IRQCFG: st_nxt.irqcfg = wbyte;
                  isr_pkg::ADDR_PWR:    st_nxt.pwr   = wbyte;
                  default: ;
                endcase
              end
            end
          end
        end
      end
      if (sck_fall && st_r.cmd_done && st_r.rd) begin
        st_nxt.miso_oe = 1'b1;
        st_nxt.miso    = st_r.tx[3'h7 - st_r.bitc];
      end
    end
    if (st_r.cmd_done && st_r.rd && !st_r.miso_oe && cs_act) st_nxt.miso = rbyte[7];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r        <= '0;
      st_r.cs_s   <= 3'h7;
      st_r.rpmax  <= isr_pkg::RST_RPMAX;
      st_r.rpmin  <= isr_pkg::RST_RPMIN;
      st_r.wdog   <= isr_pkg::RST_WDOG;
      st_r.conf   <= isr_pkg::RST_CONF;
      st_r.rsvff  <= isr_pkg::RST_RSVFF;
      st_r.thi    <= isr_pkg::RST_THI;
      st_r.rsv0   <= isr_pkg::RST_RSV0;
      st_r.tlo    <= isr_pkg::RST_TLO;
      st_r.irqcfg <= isr_pkg::RST_IRQCFG;
      st_r.pwr    <= isr_pkg::RST_PWR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spi_miso     = st_r.miso;
  assign spi_miso_oe  = st_r.miso_oe;
  assign upper_resistance_limit       = st_r.rpmax;
  assign lower_resistance_limit       = st_r.rpmin;
  assign wdog_freq    = st_r.wdog;
  assign conv_cfg     = st_r.conf;
  assign thr_high     = st_r.thi;
  assign thr_low      = st_r.tlo;
  assign irq_pin_mode = st_r.irqcfg[2:0];
  assign active       = st_r.pwr[isr_pkg::PWR_BIT];

  a_lock_holds: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st_r.pwr[0]) && st_r.pwr[0] |-> $stable(st_r.rpmax) && $stable(st_r.conf))
    else $error("locked register changed while active");
  // checked at the first edge after release, once the reset values have landed
  a_standby_reset: assert property (@(posedge clk)
    rst_n && !$past(rst_n) |-> !active && upper_resistance_limit == isr_pkg::RST_RPMAX
      && lower_resistance_limit == isr_pkg::RST_RPMIN)
    else $error("reset values wrong");
  a_addr_incr: assert property (@(posedge clk) disable iff (!rst_n)
    cs_act && sck_rise && st_r.cmd_done && st_r.bitc == 3'h7 |=> st_r.addr == $past(st_r.addr) + 7'h01)
    else $error("address did not advance");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !cs_act |=> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_write_only_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    !st_r.cmd_done |=> $stable(st_r.thi) && $stable(st_r.tlo))
    else $error("register written during command byte");

  a_lock_more: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st_r.pwr[0]) && st_r.pwr[0] |-> $stable(st_r.rpmin) && $stable(st_r.wdog))
    else $error("locked limit or watchdog changed while active");
  a_bitc_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !cs_act |=> st_r.bitc == 3'h0 && !st_r.cmd_done)
    else $error("bit counter not cleared while deselected");

  // main scenarios: writes, reads, refused writes, result bursts, wake-up
  c_write: cover property (@(posedge clk) st_r.cmd_done && !st_r.rd && sck_rise && st_r.bitc == 3'h7);
  c_locked_write: cover property (@(posedge clk) locked && st_r.cmd_done && !st_r.rd
    && sck_rise && st_r.bitc == 3'h7 && st_r.addr == isr_pkg::ADDR_RPMAX);
  c_burst: cover property (@(posedge clk) st_r.rd && st_r.addr == isr_pkg::ADDR_FC_HI);
  c_read:  cover property (@(posedge clk) spi_miso_oe);
  c_wake:  cover property (@(posedge clk) $rose(active));
endmodule // isr_regbank

// ==== isr_spi_host.sv ====
`timescale 1ns/1ps
module isr_spi_host (
  input  wire logic clk,      // system clock, paces the pins
  output logic      spi_cs_n, // chip select, active low
  output logic      spi_sclk, // serial clock, idle low
  output logic      spi_mosi, // data to device
  input  wire logic spi_miso  // data from device
);
  logic [7:0] bytes_q [12];
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic half();
    repeat (20) @(negedge clk);
  endtask
  // data set while sclk low; miso taken at the rise, long after its fall update
  task automatic bit_io(input logic d, output logic q);
    spi_mosi = d;
    half();
    spi_sclk = 1'b1;
    q = spi_miso;
    half();
    spi_sclk = 1'b0;
  endtask
  task automatic xfer(input logic rd, input logic [6:0] addr, input int n);
    logic [7:0] cmd;
    logic       q;
    cmd = {rd, addr};
    spi_cs_n = 1'b0;
    half();
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], q);
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(bytes_q[b][i], q);
        if (rd) bytes_q[b][i] = q;
      end
    end
    half();
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line must not hold stale data
    half();
  endtask
endmodule // isr_spi_host

// ==== test_inductive_sensor_register_bank.sv ====
`timescale 1ns/1ps
module test_inductive_sensor_register_bank;
  localparam logic [7:0] TB_ID = 8'h3d; // arbitrary identification value
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, active;
  logic        osc_flag = 1'b1, conv_ready_n = 1'b0, wake_flag = 1'b1, cmp_flag = 1'b0;
  logic [7:0]  prox_data = 8'h3c;
  logic [23:0] freq_count = 24'h0bb812;
  logic [7:0]  upper_resistance_limit, lower_resistance_limit, wdog_freq, conv_cfg, thr_high, thr_low;
  logic [2:0]  irq_pin_mode;
  int          n_errors = 0;
  int          checks = 0;
  always #2 clk = ~clk;
  isr_regbank #(.ID_VALUE(TB_ID)) i_dut (.clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .osc_flag(osc_flag), .conv_ready_n(conv_ready_n), .wake_flag(wake_flag),
    .cmp_flag(cmp_flag), .prox_data(prox_data), .freq_count(freq_count), .upper_resistance_limit(upper_resistance_limit),
    .lower_resistance_limit(lower_resistance_limit), .wdog_freq(wdog_freq), .conv_cfg(conv_cfg), .thr_high(thr_high),
    .thr_low(thr_low), .irq_pin_mode(irq_pin_mode), .active(active));
  isr_spi_host i_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset_values();
    logic [7:0] e [12];
    e = '{TB_ID, isr_pkg::RST_RPMAX, isr_pkg::RST_RPMIN, isr_pkg::RST_WDOG, isr_pkg::RST_CONF,
      isr_pkg::RST_RSV1, isr_pkg::RST_RSVFF, isr_pkg::RST_THI, 8'h00, isr_pkg::RST_TLO,
      isr_pkg::RST_IRQCFG, isr_pkg::RST_PWR};
    i_host.xfer(1'b1, isr_pkg::ADDR_ID, 12);
    for (int i = 0; i < 12; i++) chk("reset read", e[i], i_host.bytes_q[i]);
    chk("upper_resistance_limit port", 8'h0e, upper_resistance_limit);
    $display("test reset values done");
  endtask
  task automatic t_config_write();
    // reserved upper bits of the configuration are written as zeros; the 0x1b default has bit 4 set
    i_host.bytes_q[0:3] = '{8'h1f, 8'h2a, 8'h30, 8'h0a};
    i_host.xfer(1'b0, isr_pkg::ADDR_RPMAX, 4);
    chk("upper_resistance_limit", 8'h1f, upper_resistance_limit);
    chk("lower_resistance_limit", 8'h2a, lower_resistance_limit);
    chk("wdog_freq", 8'h30, wdog_freq);
    chk("conv_cfg", 8'h0a, conv_cfg);
    i_host.bytes_q[0:3] = '{8'h80, 8'h00, 8'h20, 8'h04};
    i_host.xfer(1'b0, isr_pkg::ADDR_THI, 4);
    chk("thr_high", 8'h80, thr_high);
    chk("thr_low", 8'h20, thr_low);
    chk("irq_pin_mode", 8'h04, {5'h00, irq_pin_mode});
    $display("test config write done");
  endtask
  task automatic t_results();
    logic [7:0] e [6];
    e = '{{osc_flag, conv_ready_n, wake_flag, cmp_flag, 4'h0}, 8'h00, prox_data,
      freq_count[7:0], freq_count[15:8], freq_count[23:16]};
    i_host.bytes_q[0:5] = '{8'h55, 8'h00, 8'h55, 8'h55, 8'h55, 8'h55};
    i_host.xfer(1'b0, isr_pkg::ADDR_STATUS, 6);
    i_host.xfer(1'b1, isr_pkg::ADDR_STATUS, 6);
    chk("status", e[0], i_host.bytes_q[0]);
    for (int i = 1; i < 6; i++) chk("result byte", e[i], i_host.bytes_q[i]);
    $display("test results done");
  endtask
  task automatic t_power_lock();
    chk("standby", 8'h00, {7'h00, active});
    i_host.bytes_q[0] = 8'h01;
    i_host.xfer(1'b0, isr_pkg::ADDR_PWR, 1);
    chk("active", 8'h01, {7'h00, active});
    i_host.bytes_q[0:3] = '{8'h00, 8'h1e, 8'h00, 8'h12};
    i_host.xfer(1'b0, isr_pkg::ADDR_RPMAX, 4);
    chk("locked upper_resistance_limit", 8'h1f, upper_resistance_limit);
    chk("locked conv_cfg", 8'h0a, conv_cfg);
    i_host.xfer(1'b1, 7'h30, 1);
    chk("unmapped read", 8'h00, i_host.bytes_q[0]);
    chk("miso_oe idle", 8'h00, {7'h00, spi_miso_oe});
    $display("test power lock done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_values();
    t_config_write();
    t_results();
    t_power_lock();
    give_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule // test_inductive_sensor_register_bank
